// ### logic/ccr_pkg.sv
// Shared constants and types for the call / reset / return execution block.
// Assumes a core clock at 100 MHz and four clock phases per instruction cycle.
package ccr_pkg;

  // Widths
  localparam int PC_W    = 21;
  localparam int STK_DEP = 31;
  localparam int PTR_W   = 5;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] A_INSTR  = 8'h00;
  localparam logic [7:0] A_PC     = 8'h04;
  localparam logic [7:0] A_WORK   = 8'h08;
  localparam logic [7:0] A_FLAGS  = 8'h0C;
  localparam logic [7:0] A_BANK   = 8'h10;
  localparam logic [7:0] A_SHADOW = 8'h14;
  localparam logic [7:0] A_IRQEN  = 8'h18;
  localparam logic [7:0] A_PCLAT  = 8'h1C;
  localparam logic [7:0] A_STACK  = 8'h20;
  localparam logic [7:0] A_ENGINE = 8'h24;

  // Field positions
  localparam int F_SH_FLAGS = 8;   // SHADOW[12:8]
  localparam int F_SH_BANK  = 16;  // SHADOW[19:16]
  localparam int F_HIGH_EN  = 0;   // IRQEN bits
  localparam int F_LOW_EN   = 1;
  localparam int F_RET_LOW  = 2;
  localparam int F_PCU      = 8;   // PCLAT[12:8]
  localparam int F_BUSY     = 0;   // ENGINE bits
  localparam int F_CYC2     = 1;
  localparam int F_PHASE    = 2;
  localparam int F_BAD_OP   = 4;
  localparam int F_REFUSED  = 5;
  localparam int F_PTR      = 8;

  // Instruction encodings
  localparam logic [15:0] OPC_CALL_MASK = 16'hF800;
  localparam logic [15:0] OPC_CALL_VAL  = 16'hD800;
  localparam logic [15:0] OPC_RETI_MASK = 16'hFFFE;
  localparam logic [15:0] OPC_RETI_VAL  = 16'h0010;
  localparam logic [15:0] OPC_SRST      = 16'h00FF;
  localparam logic [20:0] PC_STEP       = 21'h0_0002;

  // Instruction cycle phases
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q2 = 2'h1;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [2:0] {OP_NONE, OP_CALL, OP_RETI, OP_SRST, OP_OTHER} ccr_op_t;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [7:0]      work;
    logic [4:0]      flags;
    logic [3:0]      bank;
    logic [7:0]      work_sh;
    logic [4:0]      flags_sh;
    logic [3:0]      bank_sh;
    logic            global_high_irq_enable;
    logic            peripheral_low_irq_enable;
    logic            ret_low;
    logic [4:0]      pcu;
    logic [7:0]      pch;
    logic [15:0]     opcode;
    ccr_op_t         op;
    logic            busy;
    logic            cyc2;
    logic [1:0]      phase;
    logic            bad_op;
    logic            refused;
    logic            ack;
    logic [31:0]     dat;
  } ccr_state_t;

  // Reset value of every field is zero
  localparam ccr_state_t ST_RESET = '0;

  // Classifies an opcode
  function automatic ccr_op_t ccr_decode(input logic [15:0] opc);
    if ((opc & OPC_CALL_MASK) == OPC_CALL_VAL) return OP_CALL;
    if ((opc & OPC_RETI_MASK) == OPC_RETI_VAL) return OP_RETI;
    if (opc == OPC_SRST) return OP_SRST;
    return OP_OTHER;
  endfunction

endpackage

// ### logic/ccr_stack_if.sv
// Interface between the execution engine and its return stack.
// Assumes both ends share one clock; push and pop are one-cycle strobes.
`timescale 1ns/100ps
interface ccr_stack_if;
  logic                     push;
  logic                     pop;
  logic                     clr;
  logic [ccr_pkg::PC_W-1:0] wdata;
  logic [ccr_pkg::PC_W-1:0] top;
  logic [ccr_pkg::PTR_W-1:0] ptr;
  logic                     full;
  logic                     empty;

  modport ctl (output push, pop, clr, wdata, input top, ptr, full, empty);
  modport mem (input push, pop, clr, wdata, output top, ptr, full, empty);
endinterface

// ### logic/ccr_stack.sv
// Return stack of 31 program-counter words with a pointer.
// Assumes the engine never asks for push and pop in the same cycle.
`timescale 1ns/100ps
module ccr_stack (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Engine side
  ccr_stack_if.mem  stk
);

  typedef struct packed {
    logic [ccr_pkg::PTR_W-1:0] ptr;
  } ccr_stk_state_t;

  ccr_stk_state_t            s_r;
  ccr_stk_state_t            s_nxt;
  logic [ccr_pkg::PC_W-1:0]  mem_r [1:ccr_pkg::STK_DEP];

  // Pointer moves; push when full and pop when empty are ignored
  always_comb begin
    s_nxt = s_r;
    if (stk.clr) begin
      s_nxt.ptr = '0;
    end else if (stk.push && !stk.full) begin
      s_nxt.ptr = s_r.ptr + 5'h1;
    end else if (stk.pop && !stk.empty) begin
      s_nxt.ptr = s_r.ptr - 5'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Storage is written at the slot the pointer moves to
  always_ff @(posedge clk_i) begin
    if (stk.push && !stk.full && !stk.clr) begin
      mem_r[s_nxt.ptr] <= stk.wdata;
    end
  end

  // Flags and top word
  assign stk.ptr   = s_r.ptr;
  assign stk.full  = (s_r.ptr == 5'(ccr_pkg::STK_DEP));
  assign stk.empty = (s_r.ptr == '0);
  assign stk.top   = stk.empty ? '0 : mem_r[s_r.ptr];

endmodule

// ### logic/ccr_exec.sv
// Execution of relative call, software reset and return from interrupt.
// Assumes a classic Wishbone master; each instruction cycle is four clocks.
//
// The placing of the registers and register access over Wishbone were decided locally.
`timescale 1ns/100ps

// What this block does
// - relative call loads PC with call address plus 2 plus twice signed offset.
// - relative call pushes call address plus 2 onto the return stack.
// - software reset returns all state except Wishbone ack and read data to master-clear reset values.
// - interrupt return pops stack top into PC, sets high or low enable.
// - with fast-return bit set, restore work, flags and bank from shadows.
// - interrupt return never touches the upper and high PC latches.
module ccr_exec (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Core status
  output logic      [20:0] pc_o,
  output logic             busy_o,
  output logic             global_high_irq_enable_o,
  output logic             peripheral_low_irq_enable_o
);

  ccr_pkg::ccr_state_t s_r;
  ccr_pkg::ccr_state_t s_nxt;
  ccr_stack_if         stk ();

  logic                call_push;
  logic                reti_pop;
  logic                soft_clr;

  // Byte-lane merge of a write into the current register value
  function automatic logic [31:0] ccr_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Call target from the call address and the 11-bit signed offset
  function automatic logic [20:0] ccr_call_target(input logic [20:0] pc,
                                                  input logic [10:0] off);
    logic [20:0] off2;
    off2 = {{9{off[10]}}, off, 1'b0};
    return pc + ccr_pkg::PC_STEP + off2;
  endfunction

  // Return stack
  ccr_stack u_stack (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .stk   (stk)
  );

  // Stack requests from the engine
  assign stk.push  = call_push;
  assign stk.pop   = reti_pop;
  assign stk.clr   = soft_clr;
  assign stk.wdata = s_r.pc + ccr_pkg::PC_STEP;

  // Next state: bus access, then instruction engine
  always_comb begin
    logic [31:0] rd;
    logic [31:0] wv;
    logic        wr;
    logic        last;
    logic [31:0] w1c;
    rd        = '0;
    w1c       = '0;
    wv        = '0;
    wr        = 1'b0;
    last      = 1'b0;
    s_nxt     = s_r;
    call_push = 1'b0;
    reti_pop  = 1'b0;
    soft_clr  = 1'b0;

    // Read decode; unmapped addresses read zero
    case (wb_adr_i)
      ccr_pkg::A_INSTR:  rd[15:0] = s_r.opcode;
      ccr_pkg::A_PC:     rd[20:0] = s_r.pc;
      ccr_pkg::A_WORK:   rd[7:0]  = s_r.work;
      ccr_pkg::A_FLAGS:  rd[4:0]  = s_r.flags;
      ccr_pkg::A_BANK:   rd[3:0]  = s_r.bank;
      ccr_pkg::A_SHADOW: begin
        rd[7:0]                        = s_r.work_sh;
        rd[ccr_pkg::F_SH_FLAGS +: 5]   = s_r.flags_sh;
        rd[ccr_pkg::F_SH_BANK +: 4]    = s_r.bank_sh;
      end
      ccr_pkg::A_IRQEN: begin
        rd[ccr_pkg::F_HIGH_EN] = s_r.global_high_irq_enable;
        rd[ccr_pkg::F_LOW_EN]  = s_r.peripheral_low_irq_enable;
        rd[ccr_pkg::F_RET_LOW] = s_r.ret_low;
      end
      ccr_pkg::A_PCLAT: begin
        rd[7:0]                = s_r.pch;
        rd[ccr_pkg::F_PCU +: 5] = s_r.pcu;
      end
      ccr_pkg::A_STACK:  rd[20:0] = stk.top;
      ccr_pkg::A_ENGINE: begin
        rd[ccr_pkg::F_BUSY]       = s_r.busy;
        rd[ccr_pkg::F_CYC2]       = s_r.cyc2;
        rd[ccr_pkg::F_PHASE +: 2] = s_r.phase;
        rd[ccr_pkg::F_BAD_OP]     = s_r.bad_op;
        rd[ccr_pkg::F_REFUSED]    = s_r.refused;
        rd[ccr_pkg::F_PTR +: 5]   = stk.ptr;
      end
      default: rd = '0;
    endcase

    // Ack one cycle after the request; data latched with it
    s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
    if (s_nxt.ack) s_nxt.dat = rd;

    // Writes land on the edge where the master sees ack
    wr = wb_cyc_i && wb_stb_i && wb_we_i && s_r.ack;
    wv = ccr_merge(rd, wb_dat_i, wb_sel_i);
    // Clear bits count only in the byte lanes actually written
    w1c = ccr_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    if (wr) begin
      case (wb_adr_i)
        ccr_pkg::A_INSTR: begin
          if (s_r.busy) begin
            s_nxt.refused = 1'b1;
          end else begin
            s_nxt.opcode = wv[15:0];
            s_nxt.op     = ccr_pkg::ccr_decode(wv[15:0]);
            s_nxt.busy   = 1'b1;
            s_nxt.cyc2   = 1'b0;
            s_nxt.phase  = ccr_pkg::PH_Q1;
            if (s_nxt.op == ccr_pkg::OP_OTHER) s_nxt.bad_op = 1'b1;
          end
        end
        ccr_pkg::A_PC:     s_nxt.pc    = wv[20:0];
        ccr_pkg::A_WORK:   s_nxt.work  = wv[7:0];
        ccr_pkg::A_FLAGS:  s_nxt.flags = wv[4:0];
        ccr_pkg::A_BANK:   s_nxt.bank  = wv[3:0];
        ccr_pkg::A_SHADOW: begin
          s_nxt.work_sh  = wv[7:0];
          s_nxt.flags_sh = wv[ccr_pkg::F_SH_FLAGS +: 5];
          s_nxt.bank_sh  = wv[ccr_pkg::F_SH_BANK +: 4];
        end
        ccr_pkg::A_IRQEN: begin
          s_nxt.global_high_irq_enable    = wv[ccr_pkg::F_HIGH_EN];
          s_nxt.peripheral_low_irq_enable = wv[ccr_pkg::F_LOW_EN];
          s_nxt.ret_low = wv[ccr_pkg::F_RET_LOW];
        end
        ccr_pkg::A_PCLAT: begin
          s_nxt.pch = wv[7:0];
          s_nxt.pcu = wv[ccr_pkg::F_PCU +: 5];
        end
        ccr_pkg::A_ENGINE: begin
          // Write one to clear; a refusal in the same cycle is not possible
          if (w1c[ccr_pkg::F_BAD_OP])  s_nxt.bad_op  = 1'b0;
          if (w1c[ccr_pkg::F_REFUSED]) s_nxt.refused = 1'b0;
        end
        default: ;
      endcase
    end

    // Instruction engine, one phase per clock
    if (s_r.busy) begin
      s_nxt.phase = s_r.phase + 2'h1;
      last        = (s_r.phase == ccr_pkg::PH_Q4);
      case (s_r.op)
        ccr_pkg::OP_CALL: begin
          if (!s_r.cyc2 && s_r.phase == ccr_pkg::PH_Q2) call_push = 1'b1;
          if (!s_r.cyc2 && last) s_nxt.pc = ccr_call_target(s_r.pc, s_r.opcode[10:0]);
        end
        ccr_pkg::OP_RETI: begin
          if (!s_r.cyc2 && last) begin
            reti_pop = 1'b1;
            s_nxt.pc = stk.top;
            if (s_r.ret_low) s_nxt.peripheral_low_irq_enable = 1'b1;
            else             s_nxt.global_high_irq_enable    = 1'b1;
            if (s_r.opcode[0]) begin
              s_nxt.work  = s_r.work_sh;
              s_nxt.flags = s_r.flags_sh;
              s_nxt.bank  = s_r.bank_sh;
            end
          end
        end
        ccr_pkg::OP_SRST: begin
          if (s_r.phase == ccr_pkg::PH_Q2) begin
            soft_clr    = 1'b1;
            s_nxt       = ccr_pkg::ST_RESET;
            s_nxt.ack   = wb_cyc_i && wb_stb_i && !s_r.ack;
            s_nxt.dat   = s_nxt.ack ? rd : s_r.dat;
            last        = 1'b0;
          end
        end
        default: ;
      endcase
      // two-cycle ops run an idle second cycle
      if (last) begin
        if ((s_r.op == ccr_pkg::OP_CALL || s_r.op == ccr_pkg::OP_RETI) && !s_r.cyc2) begin
          s_nxt.cyc2 = 1'b1;
        end else begin
          s_nxt.busy = 1'b0;
          s_nxt.cyc2 = 1'b0;
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= ccr_pkg::ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state
  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign pc_o     = s_r.pc;
  assign busy_o   = s_r.busy;
  assign global_high_irq_enable_o    = s_r.global_high_irq_enable;
  assign peripheral_low_irq_enable_o = s_r.peripheral_low_irq_enable;

endmodule

// ### testbench/ccr_exec_props.sv
// Port assertions for the call, reset and return execution block.
// Assumes a bind onto ccr_exec and a single clock domain.
`timescale 1ns/100ps
module ccr_exec_props (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Core status
  input wire logic [20:0] pc_o,
  input wire logic        busy_o,
  input wire logic        global_high_irq_enable_o,
  input wire logic        peripheral_low_irq_enable_o
);
  logic [15:0] opc_r;
  logic [20:0] pc0_r;
  logic        req;
  logic        is_call;
  logic        is_reti;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request and opcode decode
  assign req     = wb_cyc_i & wb_stb_i;
  assign is_call = opc_r[15:11] == 5'h1B;
  assign is_reti = opc_r[15:1] == 15'h0008;
  // Opcode and PC held from the issuing write
  always_ff @(posedge clk_i) begin
    if (req & wb_ack_o & wb_we_i & (wb_adr_i == ccr_pkg::A_INSTR) & !busy_o) begin
      opc_r <= wb_dat_i[15:0];
      pc0_r <= pc_o;
    end
  end
  a_ack_next: assert property (req & !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack not a pulse");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("ack no request");
  a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
    pc_o == 21'h00_0000 && !busy_o && !global_high_irq_enable_o &&
    !peripheral_low_irq_enable_o) else $error("reset state");
  a_call_target: assert property ($rose(busy_o) && is_call |-> ##4
    pc_o == pc0_r + 21'h00_0002 + {{9{opc_r[10]}}, opc_r[10:0], 1'b0}) else $error("call pc");
  a_two_cycles: assert property ($rose(busy_o) && (is_call || is_reti) |->
    busy_o[*8] ##1 !busy_o) else $error("two cycle length");
  a_reti_enable: assert property ($rose(busy_o) && is_reti |-> ##4
    (global_high_irq_enable_o || peripheral_low_irq_enable_o)) else $error("enable not set");
  a_pc_hold: assert property (!busy_o && !(req && wb_we_i && wb_adr_i == ccr_pkg::A_PC)
    |=> $stable(pc_o)) else $error("pc moved idle");
  a_en_hold: assert property (!busy_o && !(req && wb_we_i && wb_adr_i == ccr_pkg::A_IRQEN)
    |=> $stable({global_high_irq_enable_o, peripheral_low_irq_enable_o}))
    else $error("enables moved idle");
  a_srst_clear: assert property ($rose(busy_o) && opc_r == 16'h00FF |->
    busy_o[*2] ##1 (!busy_o && pc_o == 21'h00_0000 && !global_high_irq_enable_o &&
    !peripheral_low_irq_enable_o)) else $error("soft reset state");
  c_call: cover property ($rose(busy_o) && is_call);
  c_reti_low: cover property ($rose(busy_o) && is_reti ##4 peripheral_low_irq_enable_o);
  c_srst: cover property ($rose(busy_o) && opc_r == 16'h00FF);
endmodule
bind ccr_exec ccr_exec_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_o(pc_o),
  .busy_o(busy_o), .global_high_irq_enable_o(global_high_irq_enable_o),
  .peripheral_low_irq_enable_o(peripheral_low_irq_enable_o));

// ### testbench/tb_top.sv
// Self-checking bench for the execution block over Wishbone.
// Assumes ack one cycle after a request and busy low between instructions.
`timescale 1ns/100ps
module tb_top;
  logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, busy, irq_hi, irq_lo, s, lo;
  logic [3:0]  wb_sel, sel_req;
  logic [7:0]  wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd, top, wv, fv, bv, shv, plv;
  logic [20:0] pcx, pc_pin;
  logic [10:0] n;
  int          n_fail, n_tests, seed, cyc_cnt;
  ccr_exec i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .pc_o(pc_pin), .busy_o(busy),
    .global_high_irq_enable_o(irq_hi), .peripheral_low_irq_enable_o(irq_lo));
  // Call target from issue address and offset
  function automatic logic [31:0] tgt(input logic [20:0] p, input logic [10:0] k);
    return {11'h000, p + 21'h00_0002 + {{9{k[10]}}, k, 1'b0}};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic Wishbone cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= sel_req;
    wb_wdat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    check(what, rd, exp);
  endtask
  task automatic exec(input logic [15:0] op);
    xfer(1'b1, ccr_pkg::A_INSTR, {16'h0000, op});
    do @(posedge clk_i); while (busy !== 1'b0);
  endtask
  task automatic all_zero;
    for (int a = 4; a <= 36; a += 4) rdchk(8'(a), 32'h0000_0000, "zero");
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang limit
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    {n_fail, n_tests, cyc_cnt} = 0;
    seed = 67941;
    {wb_sel, sel_req} = 8'hFF;
    {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = {1'b1, 43'h0};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    all_zero();
    xfer(1'b1, 8'h30, $random(seed));
    rdchk(8'h30, 32'h0000_0000, "unmapped");
    // Byte enables: lanes off leave WORK alone, lane 0 writes it
    xfer(1'b1, ccr_pkg::A_WORK, 32'h0000_005A);
    sel_req = 4'hE;
    xfer(1'b1, ccr_pkg::A_WORK, $random(seed));
    rdchk(ccr_pkg::A_WORK, 32'h0000_005A, "sel_skip");
    wv = $random(seed);
    sel_req = 4'h1;
    xfer(1'b1, ccr_pkg::A_WORK, wv);
    sel_req = 4'hF;
    rdchk(ccr_pkg::A_WORK, {24'h0, wv[7:0]}, "sel_lane0");
    // Calls with offset bounds then random offsets
    for (int i = 0; i < 12; i++) begin
      n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($random(seed));
      pcx = 21'($random(seed)) & 21'h1F_FFFE;
      xfer(1'b1, ccr_pkg::A_PC, {11'h000, pcx});
      exec(16'hD800 | {5'h00, n});
      rdchk(ccr_pkg::A_PC, tgt(pcx, n), "call_pc");
      check("pc_pin", {11'h000, pc_pin}, tgt(pcx, n));
      rdchk(ccr_pkg::A_STACK, {11'h000, pcx + 21'h00_0002}, "pushed");
      rdchk(ccr_pkg::A_ENGINE, 32'(i + 1) << 8, "stack_ptr");
    end
    // Interrupt return, every fast bit and enable choice
    for (int k = 0; k < 4; k++) begin
      {lo, s} = 2'(k);
      {wv, fv, bv, shv, plv} = {$random(seed), $random(seed), $random(seed),
        $random(seed), $random(seed)};
      wv &= 32'h0000_00FF;
      fv &= 32'h0000_001F;
      bv &= 32'h0000_000F;
      shv &= 32'h000F_1FFF;
      plv &= 32'h0000_1FFF;
      xfer(1'b1, ccr_pkg::A_IRQEN, {29'h0, lo, 2'b00});
      xfer(1'b1, ccr_pkg::A_WORK, wv);
      xfer(1'b1, ccr_pkg::A_FLAGS, fv);
      xfer(1'b1, ccr_pkg::A_BANK, bv);
      xfer(1'b1, ccr_pkg::A_SHADOW, shv);
      xfer(1'b1, ccr_pkg::A_PCLAT, plv);
      xfer(1'b0, ccr_pkg::A_STACK, 32'h0000_0000);
      top = rd;
      exec({15'h0008, s});
      rdchk(ccr_pkg::A_PC, top, "reti_pc");
      rdchk(ccr_pkg::A_IRQEN, {29'h0, lo, lo, ~lo}, "reti_en");
      check("irq_en_pins", {30'h0, irq_lo, irq_hi}, {30'h0, lo, ~lo});
      check("reti_pc_pin", {11'h000, pc_pin}, top);
      rdchk(ccr_pkg::A_WORK, s ? {24'h0, shv[7:0]} : wv, "work");
      rdchk(ccr_pkg::A_FLAGS, s ? {27'h0, shv[12:8]} : fv, "flags");
      rdchk(ccr_pkg::A_BANK, s ? {28'h0, shv[19:16]} : bv, "bank");
      rdchk(ccr_pkg::A_PCLAT, plv, "latches");
    end
    // Unknown opcode sets bad_op; an issue while busy is refused
    xfer(1'b1, ccr_pkg::A_INSTR, 32'h0000_1234);
    xfer(1'b1, ccr_pkg::A_INSTR, 32'h0000_D800);
    do @(posedge clk_i); while (busy !== 1'b0);
    bv = (32'h1 << ccr_pkg::F_BAD_OP) | (32'h1 << ccr_pkg::F_REFUSED);
    fv = bv | (32'h8 << ccr_pkg::F_PTR);
    rdchk(ccr_pkg::A_ENGINE, fv, "err_flags");
    // Clear bits outside the written lanes must not clear
    sel_req = 4'hE;
    xfer(1'b1, ccr_pkg::A_ENGINE, 32'hFFFF_FFFF);
    sel_req = 4'hF;
    rdchk(ccr_pkg::A_ENGINE, fv, "w1c_lane_off");
    xfer(1'b1, ccr_pkg::A_ENGINE, bv);
    rdchk(ccr_pkg::A_ENGINE, 32'h8 << ccr_pkg::F_PTR, "w1c_clear");
    // Software reset clears everything again
    exec(16'h00FF);
    all_zero();
    // Return with an empty stack lands at zero and sets the high enable
    exec(16'h0010);
    rdchk(ccr_pkg::A_PC, 32'h0000_0000, "empty_pop");
    check("irq_hi_pin", {31'h0, irq_hi}, 32'h0000_0001);
    test_done();
  end
endmodule
